// File: core/can_selective_wake_detector.sv
module can_selective_wake_detector import swk_pkg::*; #(
    parameter int unsigned SILENCE_CYCLES = SILENCE_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // bus side, from the bit decoder
    input wire logic bus_dominant,
    input wire logic bit_tick,
    input wire logic bias_on,
    input wire logic frame_sof,
    input wire logic frame_crc_ok,
    input wire frame_t frame_rx,
    input wire logic proto_error,
    // control bits
    input wire logic [2:0] can_mode,
    input wire sbc_mode_t sbc_mode,
    input wire logic fd_tolerance_enable,
    input wire logic error_count_disable,
    input wire logic global_irq_enable,
    input wire logic bus_timeout_irq_mask,
    input wire filter_cfg_t filter_cfg,
    // software strobes
    input wire logic cfg_valid_set,
    input wire logic filter_write,
    input wire logic fault_clear,
    input wire logic timeout_clear,
    input wire logic wake_clear,
    input wire logic sbc_restart,
    input wire logic sleep_entry,
    // status and events
    output swk_status_t selective_wake_status,
    output logic [5:0] frame_error_count,
    output logic filter_config_valid,
    output logic transceiver_woken,
    output logic sof_enable,
    output logic irq_req,
    output logic wake_restart_req
);

    // =======
    // helpers
    function automatic logic is_swk_mode(input logic [2:0] m);
        is_swk_mode = m[2] & (m[1] | m[0]);
    endfunction : is_swk_mode

    function automatic logic is_off_mode(input logic [2:0] m);
        is_off_mode = (m[1:0] == 2'h0);
    endfunction : is_off_mode

    // =======
    // reset release
    logic rst_s1_r, rst_s2_r;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    wire logic rst_sync_n = rst_s2_r;

    typedef enum logic [2:0] {
        ST_OFF, ST_WK, ST_WUP1, ST_WUF, ST_WUP2, ST_WOKEN
    } swk_state_t;

    swk_state_t state_r, state_nxt;
    logic [2:0] mode_prev_r;
    logic [5:0] frame_error_count_r;
    logic fault_r, cfg_valid_r, cfg_valid_prev_r;
    logic bus_wake_r, pat_flag_r, frm_flag_r, to_flag_r, sil_flag_r;
    logic lock_r, armed_r, woke_frame_sleep_r;
    logic irq_r, restart_r;

    // =======
    // mode tracking: a changed mode code or sleep entry rearms
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) mode_prev_r <= MODE_OFF;
        else mode_prev_r <= can_mode;
    end
    wire logic mode_change = (can_mode != mode_prev_r);
    wire logic rearm = mode_change | sleep_entry;
    wire logic swk_sel = is_swk_mode(can_mode);
    // config check runs when selective wake is newly requested
    wire logic swk_enable_req = swk_sel & mode_change &
                                ~is_swk_mode(mode_prev_r);
    wire logic swk_enabled = swk_sel & ~fault_r;

    // =======
    // wake pattern: dominant, recessive, dominant, each dominant long
    typedef enum logic [1:0] {P_IDLE, P_DOM1, P_REC, P_DOM2} pat_t;
    pat_t pat_r;
    logic [15:0] dom_cnt_r;
    logic pattern_hit;
    wire logic dom_long = (dom_cnt_r >= 16'(WAKE_DOMINANT_CYC - 1));

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pat_r <= P_IDLE;
            dom_cnt_r <= 16'h0000;
        end else begin
            dom_cnt_r <= bus_dominant ?
                (dom_long ? dom_cnt_r : dom_cnt_r + 16'h0001) : 16'h0000;
            case (pat_r)
                P_IDLE: if (bus_dominant) pat_r <= P_DOM1;
                P_DOM1: begin
                    if (!bus_dominant) pat_r <= dom_long ? P_REC : P_IDLE;
                end
                P_REC: if (bus_dominant) pat_r <= P_DOM2;
                P_DOM2: begin
                    if (dom_long) pat_r <= P_IDLE;
                    else if (!bus_dominant) pat_r <= P_REC;
                end
                default: pat_r <= P_IDLE;
            endcase
        end
    end
    assign pattern_hit = (pat_r == P_DOM2) & dom_long & bus_dominant;

    // =======
    // silence timer, runs in frame detection and detection 2
    logic [31:0] sil_cnt_r;
    wire logic sil_watch = (state_r == ST_WUF) | (state_r == ST_WUP2);
    wire logic sil_expire = sil_watch & ~bus_dominant &
                            (sil_cnt_r >= 32'(SILENCE_CYCLES - 1));
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) sil_cnt_r <= 32'h0000_0000;
        else if (!sil_watch || bus_dominant || sil_expire)
            sil_cnt_r <= 32'h0000_0000;
        else sil_cnt_r <= sil_cnt_r + 32'h0000_0001;
    end

    // =======
    // start-of-frame gating after each count change
    logic [3:0] idle_cnt_r;
    logic frame_active_r;
    logic [2:0] skip_cnt_r;
    logic bias_prev_r;
    logic cnt_inc, cnt_dec;
    wire logic err_ev = proto_error & frame_active_r;
    wire logic ok_ev = frame_crc_ok & frame_active_r;

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) idle_cnt_r <= IDLE_RECESSIVE_BITS;
        else if (cnt_inc || cnt_dec) idle_cnt_r <= 4'h0;
        else if (bit_tick && bus_dominant && !sof_enable) idle_cnt_r <= 4'h0;
        else if (bit_tick && !sof_enable) idle_cnt_r <= idle_cnt_r + 4'h1;
    end
    assign sof_enable = (idle_cnt_r >= IDLE_RECESSIVE_BITS);

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) frame_active_r <= 1'b0;
        else if (frame_sof && sof_enable) frame_active_r <= 1'b1;
        else if (frame_crc_ok || proto_error) frame_active_r <= 1'b0;
    end

    // frames right after bias switch-on are not wake candidates
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bias_prev_r <= 1'b0;
            skip_cnt_r <= 3'h0;
        end else begin
            bias_prev_r <= bias_on;
            if (bias_on && !bias_prev_r) skip_cnt_r <= IGNORE_FRAMES;
            else if (frame_sof && sof_enable && skip_cnt_r != 3'h0)
                skip_cnt_r <= skip_cnt_r - 3'h1;
        end
    end

    // =======
    // frame filter
    logic [7:0] byte_hit;
    genvar gb;
    generate
        for (gb = 0; gb < 8; gb++) begin : g_byte
            assign byte_hit[gb] = (4'(gb) < frame_rx.dlc) &&
                |(frame_rx.data[8*gb +: 8] & filter_cfg.data_mask[8*gb +: 8]);
        end
    endgenerate

    wire logic [28:0] id_mask_eff = filter_cfg.ide ? filter_cfg.id_mask
                                   : {18'h00000, filter_cfg.id_mask[10:0]};
    wire logic id_ok = (frame_rx.ide == filter_cfg.ide) &&
        (((frame_rx.id ^ filter_cfg.id) & id_mask_eff) == 29'h0);
    wire logic dlc_ok = (frame_rx.dlc == filter_cfg.dlc);
    wire logic data_ok = (frame_rx.dlc == 4'h0) || (|byte_hit);
    // ack and eof errors come after the crc point and are not seen here
    wire logic frame_wake = ok_ev & id_ok & dlc_ok & data_ok &
        (skip_cnt_r == 3'h0) & (state_r == ST_WUF) & swk_enabled;

    // =======
    // protocol error counter
    wire logic woken = (state_r == ST_WOKEN);
    wire logic cnt_allowed =
        (can_mode[1] | (state_r == ST_WUF)) & ~woken;
    wire logic cnt_clear = (state_r == ST_WUF && sil_expire) ||
        (state_nxt == ST_WUF && state_r != ST_WUF) || rearm ||
        is_off_mode(can_mode) || (can_mode == MODE_WK) ||
        (fd_tolerance_enable && error_count_disable);
    assign cnt_inc = cnt_allowed & err_ev & ~cnt_clear;
    assign cnt_dec = cnt_allowed & ok_ev & ~cnt_clear & (frame_error_count_r != 6'h00);
    wire logic overflow = cnt_inc & (frame_error_count_r == ERR_CNT_TOP) & swk_sel;

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) frame_error_count_r <= ERR_CNT_RESET;
        else if (cnt_clear) frame_error_count_r <= ERR_CNT_RESET;
        else if (cnt_inc && frame_error_count_r != ERR_CNT_OVF)
            frame_error_count_r <= frame_error_count_r + 6'h01;
        else if (cnt_dec) frame_error_count_r <= frame_error_count_r - 6'h01;
    end
    assign frame_error_count = frame_error_count_r;

    // =======
    // transceiver wake states
    always_comb begin
        state_nxt = state_r;
        if (rearm) begin
            if (is_off_mode(can_mode)) state_nxt = ST_OFF;
            else if (!swk_sel) state_nxt = ST_WK;
            else if (swk_enable_req ? cfg_valid_r : swk_enabled)
                state_nxt = ST_WUF;
            else state_nxt = ST_WUP2;
        end else begin
            case (state_r)
                ST_OFF: state_nxt = ST_OFF;
                ST_WK: if (pattern_hit) state_nxt = ST_WOKEN;
                ST_WUP1: if (pattern_hit) state_nxt = ST_WUF;
                ST_WUF: begin
                    if (frame_wake || overflow) state_nxt = ST_WOKEN;
                    else if (sil_expire) state_nxt = ST_WUP1;
                    else if (fault_r) state_nxt = ST_WUP2;
                end
                ST_WUP2: if (pattern_hit) state_nxt = ST_WOKEN;
                ST_WOKEN: state_nxt = ST_WOKEN;
                default: state_nxt = ST_OFF;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) state_r <= ST_OFF;
        else state_r <= state_nxt;
    end
    assign transceiver_woken = woken;

    // =======
    // configuration valid bit
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cfg_valid_r <= 1'b0;
            cfg_valid_prev_r <= 1'b0;
        end else begin
            cfg_valid_prev_r <= cfg_valid_r;
            if (sbc_restart || filter_write) cfg_valid_r <= 1'b0;
            else if (cfg_valid_set) cfg_valid_r <= 1'b1;
        end
    end
    assign filter_config_valid = cfg_valid_r;

    // remembers a frame wake out of sleep for the restart check
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) woke_frame_sleep_r <= 1'b0;
        else if (frame_wake && sbc_mode == SBC_SLEEP)
            woke_frame_sleep_r <= 1'b1;
        else if (sbc_restart) woke_frame_sleep_r <= 1'b0;
    end

    // =======
    // selective wake fault flag; a set beats a clear
    wire logic cfg_lost = swk_enabled & (sbc_mode == SBC_NORMAL) &
                          cfg_valid_prev_r & ~cfg_valid_r;
    wire logic cfg_check_fail = swk_enable_req & ~cfg_valid_r;
    wire logic restart_err = sbc_restart & swk_enabled &
                             ~woke_frame_sleep_r;
    wire logic fault_set = swk_sel &
        (cfg_lost | cfg_check_fail | overflow | restart_err);
    wire logic fault_clr_ok = fault_clear &
                              ~(can_mode[2] & ~cfg_valid_r);

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) fault_r <= 1'b0;
        else if (fault_set) fault_r <= 1'b1;
        else if (swk_enable_req && cfg_valid_r) fault_r <= 1'b0;
        else if (fault_clr_ok) fault_r <= 1'b0;
    end

    // =======
    // wake flags
    wire logic plain_pat_wake = (state_r == ST_WK) & pattern_hit;
    wire logic det2_pat_wake = (state_r == ST_WUP2) & pattern_hit;
    wire logic det1_pat = (state_r == ST_WUP1) & pattern_hit;

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) pat_flag_r <= 1'b0;
        else if (det1_pat || plain_pat_wake || det2_pat_wake)
            pat_flag_r <= 1'b1;
        else if (rearm) pat_flag_r <= 1'b0;
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) frm_flag_r <= 1'b0;
        else if (frame_wake) frm_flag_r <= 1'b1;
        else if (rearm && swk_sel) frm_flag_r <= 1'b0;
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) bus_wake_r <= 1'b0;
        else if (plain_pat_wake || det2_pat_wake || frame_wake)
            bus_wake_r <= 1'b1;
        else if (wake_clear) bus_wake_r <= 1'b0;
    end

    // =======
    // bus timeout and silence
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) to_flag_r <= 1'b0;
        else if (sil_expire) to_flag_r <= 1'b1;
        else if (timeout_clear) to_flag_r <= 1'b0;
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) sil_flag_r <= 1'b0;
        else if (sil_expire) sil_flag_r <= 1'b1;
        else if (pattern_hit) sil_flag_r <= 1'b0;
    end

    // =======
    // frame lock and armed indication
    wire logic lock_run = can_mode[1] | (state_r == ST_WUF);
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) lock_r <= 1'b0;
        else if (lock_run && err_ev) lock_r <= 1'b0;
        else if (lock_run && ok_ev) lock_r <= 1'b1;
    end

    // only the entry conditions are modelled; the state clears it
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) armed_r <= 1'b0;
        else armed_r <= (state_nxt == ST_WUF) | (state_nxt == ST_WUP1) |
                        (state_nxt == ST_WUP2);
    end

    // =======
    // event outputs, one-cycle pulses from flip-flops
    wire logic awake_mode = (sbc_mode == SBC_NORMAL) | (sbc_mode == SBC_STOP);
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            irq_r <= 1'b0;
            restart_r <= 1'b0;
        end else begin
            // each timeout pulses irq when bus_timeout_irq_mask is set in normal or stop mode, even if its flag was never cleared
            irq_r <= (sil_expire & bus_timeout_irq_mask & awake_mode) |
                     (fault_set & global_irq_enable) |
                     (frame_wake & awake_mode);
            restart_r <= frame_wake & (sbc_mode == SBC_SLEEP);
        end
    end
    assign irq_req = irq_r;
    assign wake_restart_req = restart_r;

    // =======
    // status word
    always_comb begin
        selective_wake_status.swk_fault_flag = fault_r;
        selective_wake_status.bus_wake_flag = bus_wake_r;
        selective_wake_status.pattern_wake_flag = pat_flag_r;
        selective_wake_status.frame_wake_flag = frm_flag_r;
        selective_wake_status.bus_timeout_flag = to_flag_r;
        selective_wake_status.bus_silence_flag = sil_flag_r;
        selective_wake_status.frame_lock_flag = lock_r;
        selective_wake_status.selective_wake_armed_flag = armed_r;
    end

endmodule : can_selective_wake_detector

// File: core/swk_pkg.sv
// Summary of operation
// - pattern wake: two long dominant phases with recessive between
// - up to four data frames after bias switch-on may be ignored
// - identifier matches configured one on mask-enabled bits, 11 or 29
// - received length code must equal configured length code exactly
// - nonzero length: some data bit set where data mask is also set
// - frame must be error free bar ack/eof; wake only if enabled
// - counter up on stuff/crc/form error, down if nonzero on good frame
// - increment from 31: disable selective wake, wake, set fault, read 32
// - after each count change wait 6 to 10 recessive bits before SOF
// - counter counts only in normal, receive-only or frame detection
// - cleared on timeout, detect entry, rearm, off modes, fd+disable
// - counter frozen while woken, still readable
// - pattern flag set in detection 1, plain wake, detection 2; bus wake only in the last two
// - pattern flag cleared at next rearm
// - frame wake sets frame and bus wake flags, restart or irq
// - fault flag set on config error or overflow in selective mode
// - enabling runs config check; valid bit loss while enabled is error
// - restart clears valid bit; sets fault unless frame wake from sleep
// - fault not clearable while mode bit 2 set and valid bit clear
// - silence timeout sets timeout flag; each event may raise irq
// - silence flag set on timeout, cleared by wake pattern
// - frame lock set on clean frame, cleared on protocol error
package swk_pkg;

    // =======
    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int WAKE_DOMINANT_NS = 1000;
    localparam int WAKE_DOMINANT_CYC =
        (WAKE_DOMINANT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SILENCE_TIMEOUT_US = 1000;
    localparam int SILENCE_TIMEOUT_CYC =
        (SILENCE_TIMEOUT_US * 1000) / CLK_PERIOD_NS;

    // =======
    // counts and codes
    localparam logic [5:0] ERR_CNT_RESET = 6'h00;
    localparam logic [5:0] ERR_CNT_TOP = 6'h1F;
    localparam logic [5:0] ERR_CNT_OVF = 6'h20;
    localparam logic [2:0] IGNORE_FRAMES = 3'h4;
    localparam logic [3:0] IDLE_RECESSIVE_BITS = 4'h8;
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_WK = 3'h1;
    localparam logic [2:0] MODE_OFF_SWK = 3'h4;
    localparam logic [3:0] DLC_MAX_BYTES = 4'h8;

    // =======
    // types
    typedef enum logic [1:0] {SBC_NORMAL, SBC_STOP, SBC_SLEEP, SBC_RESTART}
        sbc_mode_t;

    typedef struct packed {
        logic ide;
        logic [28:0] id;
        logic [3:0] dlc;
        logic [63:0] data;
    } frame_t;

    typedef struct packed {
        logic ide;
        logic [28:0] id;
        logic [28:0] id_mask;
        logic [3:0] dlc;
        logic [63:0] data_mask;
    } filter_cfg_t;

    typedef struct packed {
        logic swk_fault_flag;
        logic bus_wake_flag;
        logic pattern_wake_flag;
        logic frame_wake_flag;
        logic bus_timeout_flag;
        logic bus_silence_flag;
        logic frame_lock_flag;
        logic selective_wake_armed_flag;
    } swk_status_t;

endpackage : swk_pkg

// File: verification/can_bus_node.sv
// =======
// bus nodes seen through the bit decoder
module can_bus_node import swk_pkg::*; (
    // clock
    input wire logic ref_clk,
    // decoded bus events
    output logic bus_dominant,
    output logic bit_tick,
    output logic frame_sof,
    output logic frame_crc_ok,
    output frame_t frame_rx,
    output logic proto_error
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] tick_r = 2'h0;
    initial begin
        {bus_dominant, bit_tick, frame_sof, frame_crc_ok, proto_error} = '0;
        frame_rx = '0;
    end
    // sample point every four clocks
    always @(posedge ref_clk) begin
        #2;
        tick_r = tick_r + 2'h1;
        bit_tick = (tick_r == 2'h0);
    end
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask : step
    // recessive bus while bit times pass
    task automatic idle_bits(input int n);
        bus_dominant = 1'b0;
        step(4 * n);
    endtask : idle_bits
    // frame body, clean crc or error
    task automatic send_frame(input frame_t f, input logic err);
        frame_sof = 1'b1;
        bus_dominant = 1'b1;
        step(1);
        frame_sof = 1'b0;
        repeat (6) begin
            bus_dominant = ~bus_dominant;
            step(1);
        end
        frame_crc_ok = !err;
        proto_error = err;
        frame_rx = f;
        step(1);
        frame_crc_ok = 1'b0;
        proto_error = 1'b0;
        frame_rx = ~f; // no stale data
        idle_bits(12);
    endtask : send_frame
    // two dominant phases with a recessive gap
    task automatic pattern(input int n);
        bus_dominant = 1'b1;
        step(n);
        idle_bits(3);
        bus_dominant = 1'b1;
        step(n);
        idle_bits(3);
    endtask : pattern
endmodule : can_bus_node

// File: verification/can_selective_wake_detector_bench.sv
// =======
// self-checking bench
module can_selective_wake_detector_bench import swk_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SIL = 200; // short silence keeps the run brief
    typedef struct packed {
        logic [28:0] id;
        logic [3:0] dlc;
        logic [63:0] data;
        logic [3:0] cfg_dlc;
        logic err;
        logic wake;
    } row_t;
    row_t rows [7] = '{
        '{29'h123, 4'h2, 64'h10, 4'h2, 1'b0, 1'b1},
        '{29'h12A, 4'h2, 64'h80, 4'h2, 1'b0, 1'b1},
        '{29'h133, 4'h2, 64'h10, 4'h2, 1'b0, 1'b0},
        '{29'h123, 4'h3, 64'h10, 4'h2, 1'b0, 1'b0},
        '{29'h123, 4'h2, 64'h0F, 4'h2, 1'b0, 1'b0},
        '{29'h123, 4'h2, 64'h10, 4'h2, 1'b1, 1'b0},
        '{29'h123, 4'h0, 64'h00, 4'h0, 1'b0, 1'b1}};
    logic ref_clk = 1'b0, rst_n = 1'b0, bias_on = 1'b0;
    logic cfg_valid_set, filter_write, fault_clear, sbc_restart, flag_clear;
    logic fd_tolerance_enable, error_count_disable, bus_timeout_irq_mask;
    logic [2:0] can_mode;
    filter_cfg_t filter_cfg;
    logic bus_dominant, bit_tick, frame_sof, frame_crc_ok, proto_error;
    frame_t frame_rx;
    swk_status_t selective_wake_status, s;
    logic [5:0] frame_error_count;
    logic filter_config_valid, transceiver_woken, sof_enable, irq_req;
    int n_errors = 0, num_checks = 0;
    const frame_t junk = '{1'b0, 29'h7FF, 4'h1, 64'h00};
    assign s = selective_wake_status;
    always #25 ref_clk = ~ref_clk;
    can_bus_node bus (.ref_clk, .bus_dominant, .bit_tick, .frame_sof,
        .frame_crc_ok, .frame_rx, .proto_error);
    can_selective_wake_detector #(.SILENCE_CYCLES(SIL)) dut (.ref_clk,
        .rst_n, .bus_dominant, .bit_tick, .bias_on, .frame_sof,
        .frame_crc_ok, .frame_rx, .proto_error, .can_mode,
        .sbc_mode(SBC_NORMAL), .fd_tolerance_enable, .error_count_disable,
        .global_irq_enable(1'b1), .bus_timeout_irq_mask, .filter_cfg,
        .cfg_valid_set, .filter_write, .fault_clear, .timeout_clear(flag_clear),
        .wake_clear(flag_clear), .sbc_restart, .sleep_entry(1'b0),
        .selective_wake_status, .frame_error_count, .filter_config_valid,
        .transceiver_woken, .sof_enable, .irq_req, .wake_restart_req());
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask : step
    task automatic check(input string name, input logic [63:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    // leave and re-enter a mode to rearm; clears bus wake and timeout too
    task automatic rearm(input logic [2:0] m);
        can_mode = 3'h0;
        flag_clear = 1'b1;
        step(1);
        flag_clear = 1'b0;
        step(2);
        can_mode = m;
        step(3);
    endtask : rearm
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    // watchdog, over twelve times the expected run
    initial begin
        repeat (40000) @(posedge ref_clk);
        n_errors++;
        wrap_up();
    end
    initial begin
        {cfg_valid_set, filter_write, fault_clear, sbc_restart} = '0;
        flag_clear = 1'b0;
        {fd_tolerance_enable, error_count_disable} = '0;
        bus_timeout_irq_mask = 1'b0;
        can_mode = 3'h0;
        filter_cfg = '{1'b0, 29'h123, 29'h7F0, 4'h2, 64'hF0};
        step(6);
        rst_n = 1'b1;
        step(3);
        check("count", frame_error_count, 6'h00);
        check("status", s, 8'h00);
        bias_on = 1'b1;
        cfg_valid_set = 1'b1;
        step(1);
        cfg_valid_set = 1'b0;
        rearm(3'h5);
        check("fault", s.swk_fault_flag, 1'b0);
        repeat (4) bus.send_frame(junk, 1'b0);
        foreach (rows[i]) begin
            filter_cfg.dlc = rows[i].cfg_dlc;
            rearm(3'h5);
            bus.send_frame('{1'b0, rows[i].id, rows[i].dlc, rows[i].data},
                rows[i].err);
            check("frame wake", s.frame_wake_flag, rows[i].wake);
            check("bus wake", s.bus_wake_flag, rows[i].wake);
        end
        // counter steps, clear, overflow, freeze
        rearm(3'h5);
        repeat (2) bus.send_frame(junk, 1'b1);
        check("count", frame_error_count, 6'h02);
        bus.send_frame(junk, 1'b0);
        check("count", frame_error_count, 6'h01);
        {fd_tolerance_enable, error_count_disable} = 2'h3;
        step(2);
        check("count", frame_error_count, 6'h00);
        {fd_tolerance_enable, error_count_disable} = 2'h0;
        repeat (32) bus.send_frame(junk, 1'b1);
        check("count", frame_error_count, 6'h20);
        check("fault", s.swk_fault_flag, 1'b1);
        check("woken", transceiver_woken, 1'b1);
        bus.send_frame(junk, 1'b1);
        check("count", frame_error_count, 6'h20);
        // patterns either side of the minimum
        rearm(3'h1);
        check("count", frame_error_count, 6'h00);
        bus.pattern(18);
        check("pattern", s.pattern_wake_flag, 1'b0);
        bus.pattern(22);
        check("pattern", s.pattern_wake_flag, 1'b1);
        check("bus wake", s.bus_wake_flag, 1'b1);
        rearm(3'h1);
        check("pattern", s.pattern_wake_flag, 1'b0);
        // silent bus, then a pattern
        bus_timeout_irq_mask = 1'b1;
        rearm(3'h5);
        step(SIL + 20);
        check("timeout", s.bus_timeout_flag, 1'b1);
        check("silence", s.bus_silence_flag, 1'b1);
        bus.pattern(22);
        check("silence", s.bus_silence_flag, 1'b0);
        check("pattern", s.pattern_wake_flag, 1'b1);
        // config loss, refused clear, restart
        filter_write = 1'b1;
        step(1);
        filter_write = 1'b0;
        step(2);
        check("valid", filter_config_valid, 1'b0);
        check("fault", s.swk_fault_flag, 1'b1);
        fault_clear = 1'b1;
        step(1);
        fault_clear = 1'b0;
        step(2);
        check("fault", s.swk_fault_flag, 1'b1);
        cfg_valid_set = 1'b1;
        step(1);
        cfg_valid_set = 1'b0;
        rearm(3'h5);
        check("fault", s.swk_fault_flag, 1'b0);
        sbc_restart = 1'b1;
        step(1);
        sbc_restart = 1'b0;
        step(2);
        check("valid", filter_config_valid, 1'b0);
        check("fault", s.swk_fault_flag, 1'b1);
        wrap_up();
    end
endmodule : can_selective_wake_detector_bench

// File: verification/swk_checker_asserts.sv
// =======
// port-level checker
module swk_checker import swk_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // inputs watched
    input wire logic proto_error,
    input wire logic frame_crc_ok,
    input wire logic [2:0] can_mode,
    input wire sbc_mode_t sbc_mode,
    input wire logic bus_timeout_irq_mask,
    input wire logic fault_clear,
    // outputs watched
    input wire swk_status_t selective_wake_status,
    input wire logic [5:0] frame_error_count,
    input wire logic filter_config_valid,
    input wire logic transceiver_woken,
    input wire logic sof_enable,
    input wire logic irq_req
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // a counted frame outcome closes the start gate for several bits
    sequence step_seen;
        $past(proto_error || frame_crc_ok) && $changed(frame_error_count);
    endsequence
    sequence gate_shut;
        !sof_enable [*8];
    endsequence
    gap_after_step_a: assert property (step_seen |-> gate_shut)
        else $error("gate open after step");
    overflow_wake_a: assert property (frame_error_count == ERR_CNT_OVF &&
        $past(frame_error_count) == ERR_CNT_TOP |->
        selective_wake_status.swk_fault_flag && transceiver_woken)
        else $error("overflow no fault");
    count_cap_a: assert property (frame_error_count <= ERR_CNT_OVF)
        else $error("count too high");
    off_clear_a: assert property (can_mode == MODE_OFF && $stable(can_mode)
        |=> frame_error_count == ERR_CNT_RESET)
        else $error("count not cleared");
    frozen_count_a: assert property (transceiver_woken &&
        $past(transceiver_woken) |-> $stable(frame_error_count))
        else $error("count not frozen");
    lock_fall_a: assert property ($fell(selective_wake_status.frame_lock_flag)
        |-> $past(proto_error))
        else $error("lock fell, no error");
    frame_wake_a: assert property ($rose(selective_wake_status.frame_wake_flag)
        |-> selective_wake_status.bus_wake_flag && transceiver_woken &&
        (sbc_mode == SBC_SLEEP || irq_req))
        else $error("frame wake incomplete");
    fault_hold_a: assert property (selective_wake_status.swk_fault_flag &&
        can_mode[2] && !filter_config_valid && fault_clear
        |=> selective_wake_status.swk_fault_flag)
        else $error("fault wrongly cleared");
    timeout_irq_a: assert property ($rose(selective_wake_status.bus_timeout_flag)
        && bus_timeout_irq_mask && sbc_mode == SBC_NORMAL |-> irq_req)
        else $error("timeout no irq");
    silence_pair_a: assert property ($rose(selective_wake_status.bus_silence_flag)
        |-> selective_wake_status.bus_timeout_flag)
        else $error("silence w/o timeout");
endmodule : swk_checker

bind can_selective_wake_detector swk_checker chk (.*);
